// ### test/usx_peer.sv
// Peer serial device: decodes frames on the line and supplies a slave clock.
`timescale 1ns/1ps
module usx_peer (
  // System clock.
  input wire logic aclk,
  // Line levels and mode.
  input wire logic txd,
  input wire logic sck,
  input wire logic sync_mode,
  input wire logic cpol,
  input wire logic run_clk,
  input wire logic [7:0] bit_clks,
  input wire logic [3:0] nbits,
  // Peer clock and decoded frame.
  output logic sck_drv,
  output logic [11:0] frame,
  output logic [7:0] nframes
);
  // Forty system clocks a period keeps the slave clock at 1 MHz.
  initial begin
    sck_drv <= 1'h0;
    forever begin
      repeat (20) @(posedge aclk);
      sck_drv <= run_clk ? ~sck_drv : cpol;
    end
  end
  task automatic wait_bit();
    if (!sync_mode) repeat (bit_clks) @(posedge aclk);
    else if (cpol) @(posedge sck);
    else @(negedge sck);
  endtask
  initial begin
    nframes = 8'h00;
    forever begin
      @(negedge txd);
      frame = 12'hFFF;
      if (!sync_mode) repeat (bit_clks / 2) @(posedge aclk);
      else wait_bit();
      for (int i = 0; i < nbits; i++) begin
        wait_bit();
        frame[i] = txd;
      end
      nframes = nframes + 8'h01;
    end
  end
endmodule // usx_peer

// ### test/usx_transmitter_chk.sv
// Checker of bus answers and line behaviour at the transmitter ports.
`timescale 1ns/1ps
module usx_transmitter_chk (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial pins and interrupt.
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe,
  input wire logic transmit_data_pin_o,
  input wire logic transmit_data_pin_oe,
  input wire logic transmit_complete_irq,
  input wire logic transmit_complete_serviced
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_start_bit;
    $fell(transmit_data_pin_o) ##0 transmit_data_pin_oe;
  endsequence
  AST_WR_RESP: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data missing");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write response repeated");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read data repeated");
  AST_IDLE_HIGH: assert property (!transmit_data_pin_oe |->
    transmit_data_pin_o) else $error("released line not high");
  AST_START_HOLD: assert property (s_start_bit |->
    !transmit_data_pin_o [*2]) else $error("start bit too short");
  AST_SCK_SLOW: assert property (serial_clock_pin_oe &&
    $changed(serial_clock_pin_o) |=> $stable(serial_clock_pin_o))
    else $error("serial clock too fast");
  AST_TXC_SERVICE: assert property (transmit_complete_serviced &&
    transmit_complete_irq |=> !transmit_complete_irq)
    else $error("complete flag kept after service");
endmodule // usx_transmitter_chk

bind usx_transmitter usx_transmitter_chk u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .serial_clock_pin_o, .serial_clock_pin_oe,
  .transmit_data_pin_o, .transmit_data_pin_oe, .transmit_complete_irq,
  .transmit_complete_serviced);

// ### test/usx_transmitter_tb.sv
// Self-checking bench for the transmitter: register access and frames.
`timescale 1ns/1ps
module usx_transmitter_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, serviced, be_irq, tc_irq;
  logic sck_o, sck_oe, sck_drv, sck, txd_o, txd_oe, txd, cp, mst;
  logic p_sync, p_cpol, p_run;
  logic [31:0] wdata, rdata;
  logic [7:0] awaddr, araddr, p_bit, nframes, n0;
  logic [3:0] wstrb, p_n;
  logic [2:0] ie;
  logic [1:0] bresp, rresp, md;
  logic [11:0] frame;
  int n_errors, comparisons;
  assign sck = sck_oe ? sck_o : sck_drv;
  assign txd = txd_oe ? txd_o : 1'h1;
  usx_transmitter uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_clock_pin_i(sck),
    .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
    .transmit_data_pin_o(txd_o), .transmit_data_pin_oe(txd_oe),
    .buffer_empty_irq(be_irq), .transmit_complete_irq(tc_irq),
    .transmit_complete_serviced(serviced));
  usx_peer peer (.aclk(aclk), .txd(txd), .sck(sck), .sync_mode(p_sync),
    .cpol(p_cpol), .run_clk(p_run), .bit_clks(p_bit), .nbits(p_n),
    .sck_drv(sck_drv), .frame(frame), .nframes(nframes));
  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d,
      input logic [1:0] r = usx_pkg::RESP_OKAY, input logic [3:0] s = 4'hF);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (awvalid && !awready || wvalid && !wready);
    while (!bvalid) @(posedge aclk);
    chk("bresp", bresp, r);
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] r = usx_pkg::RESP_OKAY);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    if (r == usx_pkg::RESP_OKAY) chk("rdata", rdata, e);
    chk("rresp", rresp, r);
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  function automatic logic [11:0] exp_frame(input int nb,
      input logic [1:0] pm, input logic [8:0] d);
    logic [11:0] e;
    e = 12'hFFF;
    for (int i = 0; i < nb; i++) e[i] = d[i];
    if (pm[1]) e[nb] = ^(e[8:0] & ~(9'h1FF << nb)) ^ pm[0];
    return e;
  endfunction
  task automatic wait_frames(input logic [7:0] n);
    int k;
    k = 0;
    while (nframes != n && k < 4000) begin
      @(posedge aclk);
      k++;
    end
    chk("frames", nframes, n);
    // The peer counts a frame inside its last stop bit; let that bit end.
    repeat (p_bit) @(posedge aclk);
  endtask
  task automatic send(input int nb, input logic [1:0] pm,
      input logic s2, d2, input logic [8:0] d);
    logic [2:0] sz;
    sz = (nb == 9) ? usx_pkg::SIZE_NINE : 3'(nb - 5);
    n0 = nframes;
    wr(usx_pkg::OFF_CTRL_ONE, {md, pm, sz, cp});
    wr(usx_pkg::OFF_CTRL_THREE, {5'h00, mst, s2, d[8]});
    wr(usx_pkg::OFF_CTRL_TWO, {3'h0, ie, 1'h1, d2});
    p_bit <= d2 ? 8'h10 : 8'h20;
    p_n <= 4'(nb + pm[1] + 1 + s2);
    wr(usx_pkg::OFF_DATA_BUF, d[7:0]);
    wait_frames(n0 + 8'h01);
    chk("frame", frame, exp_frame(nb, pm, d));
  endtask
  task automatic wrap_up();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, serviced} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {p_sync, p_cpol, p_run, cp, mst, md, ie} = 10'h000;
    {p_bit, p_n} = 12'h000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(usx_pkg::OFF_STATUS_ONE, 32'h80);
    rd(usx_pkg::OFF_DATA_BUF, 32'h0);
    rd(8'h18, 32'h0, usx_pkg::RESP_SLVERR);
    wr(8'h18, 8'hFF, usx_pkg::RESP_SLVERR);
    wr(usx_pkg::OFF_CTRL_ONE, 8'hFF, usx_pkg::RESP_OKAY, 4'h0);
    rd(usx_pkg::OFF_CTRL_ONE, 32'h0);
    wr(usx_pkg::OFF_BAUD_DIV, 8'h01);
    send(9, 2'h3, 1'h0, 1'h0, 9'h1C3);
    send(5, 2'h0, 1'h0, 1'h0, 9'h015);
    send(6, 2'h2, 1'h1, 1'h0, 9'h02D);
    send(7, 2'h3, 1'h1, 1'h1, 9'h04E);
    send(8, 2'h2, 1'h0, 1'h0, 9'h0A7);
    chk("idle line", txd, 1'h1);
    n0 = nframes;
    wr(usx_pkg::OFF_DATA_BUF, 8'h3C);
    wr(usx_pkg::OFF_DATA_BUF, 8'hC5);
    rd(usx_pkg::OFF_STATUS_ONE, 32'h00);
    wait_frames(n0 + 8'h02);
    chk("frame", frame, exp_frame(8, 2'h2, 9'h0C5));
    rd(usx_pkg::OFF_STATUS_ONE, 32'hC0);
    wr(usx_pkg::OFF_STATUS_ONE, 8'h80);
    rd(usx_pkg::OFF_STATUS_ONE, 32'h80);
    wr(usx_pkg::OFF_STATUS_ONE, 8'h40);
    rd(usx_pkg::OFF_STATUS_ONE, 32'h00);
    ie = 3'h6;
    wr(usx_pkg::OFF_CTRL_TWO, 8'h1A);
    chk("empty irq", be_irq, 1'h0);
    send(8, 2'h2, 1'h0, 1'h0, 9'h0E1);
    chk("empty irq", be_irq, 1'h1);
    wr(usx_pkg::OFF_CTRL_TWO, 8'h0A);
    chk("empty irq", be_irq, 1'h0);
    wr(usx_pkg::OFF_CTRL_TWO, 8'h16);
    chk("complete irq", tc_irq, 1'h1);
    serviced <= 1'h1;
    @(posedge aclk);
    serviced <= 1'h0;
    @(posedge aclk);
    chk("complete irq", tc_irq, 1'h0);
    rd(usx_pkg::OFF_STATUS_ONE, 32'h80);
    n0 = nframes;
    wr(usx_pkg::OFF_DATA_BUF, 8'h5A);
    wr(usx_pkg::OFF_CTRL_TWO, 8'h00);
    chk("txd_oe", txd_oe, 1'h1);
    wait_frames(n0 + 8'h01);
    chk("frame", frame, exp_frame(8, 2'h2, 9'h05A));
    repeat (40) @(posedge aclk);
    chk("txd_oe", txd_oe, 1'h0);
    {md, mst, p_sync, ie} = {usx_pkg::MODE_SYNC, 2'h3, 3'h0};
    send(8, 2'h0, 1'h0, 1'h0, 9'h0B4);
    chk("sck_oe", sck_oe, 1'h1);
    {mst, cp, p_cpol, p_run} = 4'h7;
    send(7, 2'h3, 1'h1, 1'h0, 9'h033);
    chk("sck_oe", sck_oe, 1'h0);
    p_run = 1'h0;
    wrap_up();
  end
endmodule // usx_transmitter_tb

// ### verilog/usx_pkg.sv
// Package with register map, field positions and encodings of the transmitter.
package usx_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFF_CTRL_THREE = 8'h08;
  localparam logic [7:0] OFF_STATUS_ONE = 8'h0C;
  localparam logic [7:0] OFF_BAUD_DIV = 8'h10;
  localparam logic [7:0] OFF_DATA_BUF = 8'h14;
  // control_reg_one fields.
  localparam int C1_CPOL = 0;
  localparam int C1_SIZE_LSB = 1;
  localparam int C1_PM_LSB = 4;
  localparam int C1_MODE_LSB = 6;
  // control_reg_two fields.
  localparam int C2_DBLS = 0;
  localparam int C2_TRANSMIT_ENABLE_BIT = 1;
  localparam int C2_TXCIE = 2;
  localparam int C2_DRIE = 3;
  localparam int C2_GIE = 4;
  // control_reg_three fields.
  localparam int C3_TX8 = 0;
  localparam int C3_STOP2 = 1;
  localparam int C3_MASTER = 2;
  // status_reg_one fields.
  localparam int ST_TXC = 6;
  localparam int ST_DRE = 7;
  // Reset values.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;
  // Encodings.
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] SAMPLES_NORMAL = 4'hF;
  localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h3,
    TX_PARITY = 3'h2,
    TX_STOP = 3'h6
  } usx_tx_state_type;
endpackage

// ### verilog/usx_transmitter.sv
// Serial unit transmitter with clocking, frame shifter and register slave.
// How it works
// - external serial clock goes through a synchroniser, then an edge detector.
// - serial clock pin is input as slave, driven output as master in synchronous mode.
// - synchronous data changes on one clock edge, sampled on the other.
// - polarity clear: change on rising, sample on falling; set swaps.
// - frame is start, five to nine data, optional parity, one or two stops.
// - data goes LSB first; parity sits between last data and first stop.
// - line idles high; a frame may follow another directly.
// - parity is XOR of data bits, inverted for odd parity.
// - size, parity mode and stop select fields set the frame format.
// - transmitter loads new frames only while its enable bit is set.
// - data write fills buffer; buffer moves to shifter when idle or done.
// - buffer-empty flag set when buffer empties into shifter; writing zero clears, one ignored.
// - buffer-empty interrupt is flag and its enable and global enable.
// - transmit-complete set after frame out with buffer empty; cleared three ways.
// - transmit-complete interrupt is flag and its enable and global enable.
// - parity enable inserts generated parity after the MSB.
// - clearing enable waits for the running frame; pin then released.
// - synchronous frames shift on the serial clock pin.
// - master bit picks internal clock out or external clock in.
// - size field value 111 selects nine-bit characters.
// - baud is clock over 16, 8 or 2 times divisor plus one.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module usx_transmitter #(
  parameter int ADDR_W = usx_pkg::ADDR_W
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial clock pin.
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  // Transmit data pin.
  output logic transmit_data_pin_o,
  output logic transmit_data_pin_oe,
  // Interrupt requests and service acknowledge.
  output logic buffer_empty_irq,
  output logic transmit_complete_irq,
  input wire logic transmit_complete_serviced
);

  typedef struct packed {
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] control_reg_one;
    logic [7:0] control_reg_two;
    logic [7:0] control_reg_three;
    logic [7:0] baud_divisor_reg;
    logic buffer_empty_flag;
    logic transmit_complete_flag;
    logic buf_full;
    logic [8:0] buf_data;
    logic tx_on;
    usx_pkg::usx_tx_state_type state;
    logic [8:0] shift;
    logic [3:0] bits_left;
    logic parity;
    logic second_stop;
    // A synchronous frame from idle waits for a change edge to start.
    logic lead;
    logic [3:0] sample;
    logic [7:0] div;
    logic sck_master;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic txd;
  } usx_state_type;

  usx_state_type r;
  usx_state_type next_r;

  logic [1:0] mode;
  logic sync_mode;
  logic master;
  logic cpol;
  logic [3:0] nbits;
  logic [8:0] data_mask;
  logic tick;
  logic bit_end;
  logic change_edge;
  logic advance;
  logic frame_done;
  logic do_write;
  logic [7:0] wbyte;
  logic load;

  always_comb begin
    mode = r.control_reg_one[usx_pkg::C1_MODE_LSB +: 2];
    sync_mode = (mode == usx_pkg::MODE_SYNC);
    master = r.control_reg_three[usx_pkg::C3_MASTER];
    cpol = r.control_reg_one[usx_pkg::C1_CPOL];
    // Reserved size codes fall back to eight bits.
    unique case (r.control_reg_one[usx_pkg::C1_SIZE_LSB +: 3])
      3'h0: nbits = 4'h5;
      3'h1: nbits = 4'h6;
      3'h2: nbits = 4'h7;
      usx_pkg::SIZE_NINE: nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
    // Bits above the character size are masked so that they reach
    // neither the line nor the parity.
    data_mask = 9'(({1'b0, 9'h1FF} >> (4'h9 - nbits)));
    // The divider reloads from the divisor, so a tick spans divisor + 1.
    tick = (r.div == 8'h00);
    // Asynchronous bit time is 16 or 8 baud ticks.
    bit_end = tick && (r.sample == (r.control_reg_two[usx_pkg::C2_DBLS] ?
        usx_pkg::SAMPLES_DOUBLE : usx_pkg::SAMPLES_NORMAL));
    if (master) begin
      // Master edge leaving the idle level is the change edge.
      change_edge = tick && (r.state != usx_pkg::TX_IDLE)
          && (r.sck_master == cpol);
    end else begin
      // Only the agreeing second and third stages are compared.
      change_edge = cpol ? (r.sck_s3 && !r.sck_s2)
                         : (!r.sck_s3 && r.sck_s2);
    end
    advance = sync_mode ? change_edge : bit_end;
    frame_done = advance && (r.state == usx_pkg::TX_STOP)
        && (r.second_stop || !r.control_reg_three[usx_pkg::C3_STOP2]);
    do_write = r.aw_full && r.w_full && !r.bvalid;
    wbyte = r.w_data;
    load = r.buf_full && r.control_reg_two[usx_pkg::C2_TRANSMIT_ENABLE_BIT]
        && ((r.state == usx_pkg::TX_IDLE) || frame_done);
  end

  always_comb begin
    next_r = r;
    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_full = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_full = 1'b1;
      next_r.w_data = s_axi_wdata[7:0];
      next_r.w_lane0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    // Baud divider runs freely so the rate is set by the divisor alone.
    next_r.div = tick ? r.baud_divisor_reg : 8'(r.div - 8'h01);
    if (tick) begin
      next_r.sample = bit_end ? 4'h0 : 4'(r.sample + 4'h1);
    end
    // Only stages two and three feed the edge detector, which costs two
    // clocks of delay but keeps a metastable first stage out of the logic.
    next_r.sck_s1 = serial_clock_pin_i;
    next_r.sck_s2 = r.sck_s1;
    next_r.sck_s3 = r.sck_s2;
    // The master clock finishes its last half period before it idles,
    // so no pulse shorter than one divider period leaves the pin.
    if (tick) begin
      next_r.sck_master = (r.state == usx_pkg::TX_IDLE) ? cpol
          : !r.sck_master;
    end
    // Shifter.
    if (advance) begin
      unique case (r.state)
        usx_pkg::TX_START: begin
          if (r.lead) begin
            // The start bit begins on a change edge so the peer samples it.
            next_r.lead = 1'b0;
            next_r.txd = 1'b0;
          end else begin
            next_r.state = usx_pkg::TX_DATA;
            next_r.txd = r.shift[0];
            next_r.shift = r.shift >> 1;
            next_r.bits_left = 4'(nbits - 4'h1);
          end
        end
        usx_pkg::TX_DATA: begin
          if (r.bits_left != 4'h0) begin
            next_r.txd = r.shift[0];
            next_r.shift = r.shift >> 1;
            next_r.bits_left = 4'(r.bits_left - 4'h1);
          end else if (r.control_reg_one[usx_pkg::C1_PM_LSB + 1]) begin
            next_r.state = usx_pkg::TX_PARITY;
            next_r.txd = r.parity;
          end else begin
            next_r.state = usx_pkg::TX_STOP;
            next_r.txd = 1'b1;
            next_r.second_stop = 1'b0;
          end
        end
        usx_pkg::TX_PARITY: begin
          next_r.state = usx_pkg::TX_STOP;
          next_r.txd = 1'b1;
          next_r.second_stop = 1'b0;
        end
        usx_pkg::TX_STOP: begin
          next_r.second_stop = 1'b1;
          if (frame_done) begin
            next_r.state = usx_pkg::TX_IDLE;
          end
        end
        default: begin
          next_r.state = usx_pkg::TX_IDLE;
        end
      endcase
    end
    // Completion is flagged only when no further data waits in the buffer.
    if (frame_done && !r.buf_full) begin
      next_r.transmit_complete_flag = 1'b1;
    end
    // Disable takes effect only once the shifter is idle.
    next_r.tx_on = r.control_reg_two[usx_pkg::C2_TRANSMIT_ENABLE_BIT]
        || (next_r.state != usx_pkg::TX_IDLE);
    if (next_r.state == usx_pkg::TX_IDLE) begin
      next_r.txd = 1'b1;
    end
    if (load) begin
      next_r.state = usx_pkg::TX_START;
      // A synchronous frame from idle holds the line high until the first
      // change edge; one that follows a frame directly starts at once.
      next_r.lead = sync_mode && !frame_done;
      next_r.txd = sync_mode && !frame_done;
      next_r.shift = r.buf_data & data_mask;
      next_r.parity = (^(r.buf_data & data_mask))
          ^ r.control_reg_one[usx_pkg::C1_PM_LSB];
      next_r.sample = 4'h0;
      next_r.buf_full = 1'b0;
      next_r.tx_on = 1'b1;
    end
    // Register writes.
    // One write is decoded per response; a new address or data word waits
    // until the master has taken the response.
    if (do_write) begin
      next_r.aw_full = 1'b0;
      next_r.w_full = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = usx_pkg::RESP_OKAY;
      unique case (r.aw_addr)
        usx_pkg::OFF_CTRL_ONE:
          if (r.w_lane0) next_r.control_reg_one = wbyte;
        usx_pkg::OFF_CTRL_TWO:
          if (r.w_lane0) next_r.control_reg_two = wbyte;
        usx_pkg::OFF_CTRL_THREE:
          if (r.w_lane0) next_r.control_reg_three = wbyte;
        usx_pkg::OFF_BAUD_DIV:
          if (r.w_lane0) next_r.baud_divisor_reg = wbyte;
        usx_pkg::OFF_STATUS_ONE: begin
          if (r.w_lane0 && !wbyte[usx_pkg::ST_DRE]) begin
            next_r.buffer_empty_flag = 1'b0;
          end
          if (r.w_lane0 && !wbyte[usx_pkg::ST_TXC] && !frame_done) begin
            next_r.transmit_complete_flag = 1'b0;
          end
        end
        usx_pkg::OFF_DATA_BUF: begin
          if (r.w_lane0) begin
            // The ninth bit is taken from its control bit at this write.
            next_r.buf_data = {r.control_reg_three[usx_pkg::C3_TX8],
                wbyte};
            next_r.buf_full = 1'b1;
            next_r.buffer_empty_flag = 1'b0;
            next_r.transmit_complete_flag = 1'b0;
          end
        end
        default: next_r.bresp = usx_pkg::RESP_SLVERR;
      endcase
    end
    if (transmit_complete_serviced && !frame_done) begin
      next_r.transmit_complete_flag = 1'b0;
    end
    // The buffer emptying into the shifter wins over any clear, but a
    // data write in the same cycle refills the buffer at once.
    if (load && !next_r.buf_full) begin
      next_r.buffer_empty_flag = 1'b1;
    end
    // Read channel.
    // Read data are registered, so rvalid rises one clock after the address
    // is taken, and arready stays low until the data are accepted.
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = usx_pkg::RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        usx_pkg::OFF_CTRL_ONE: next_r.rdata[7:0] = r.control_reg_one;
        usx_pkg::OFF_CTRL_TWO: next_r.rdata[7:0] = r.control_reg_two;
        usx_pkg::OFF_CTRL_THREE: next_r.rdata[7:0] = r.control_reg_three;
        usx_pkg::OFF_BAUD_DIV: next_r.rdata[7:0] = r.baud_divisor_reg;
        usx_pkg::OFF_STATUS_ONE: begin
          next_r.rdata[usx_pkg::ST_DRE] = r.buffer_empty_flag;
          next_r.rdata[usx_pkg::ST_TXC] = r.transmit_complete_flag;
        end
        // The data buffer is write-only and reads as zero.
        usx_pkg::OFF_DATA_BUF: next_r.rdata = 32'h0000_0000;
        default: next_r.rresp = usx_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.control_reg_one <= usx_pkg::RST_CTRL;
      r.control_reg_two <= usx_pkg::RST_CTRL;
      r.control_reg_three <= usx_pkg::RST_CTRL;
      r.baud_divisor_reg <= usx_pkg::RST_BAUD;
      r.buffer_empty_flag <= 1'b1;
      r.state <= usx_pkg::TX_IDLE;
      r.txd <= 1'b1;
      r.sck_s1 <= 1'b1;
      r.sck_s2 <= 1'b1;
      r.sck_s3 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = !r.aw_full && !r.bvalid;
  assign s_axi_wready = !r.w_full && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;
  assign serial_clock_pin_o = r.sck_master;
  assign serial_clock_pin_oe = sync_mode && master;
  assign transmit_data_pin_o = r.txd;
  assign transmit_data_pin_oe = r.tx_on;
  assign buffer_empty_irq = r.buffer_empty_flag
      && r.control_reg_two[usx_pkg::C2_DRIE]
      && r.control_reg_two[usx_pkg::C2_GIE];
  assign transmit_complete_irq = r.transmit_complete_flag
      && r.control_reg_two[usx_pkg::C2_TXCIE]
      && r.control_reg_two[usx_pkg::C2_GIE];

endmodule // usx_transmitter
